// *** trb_bank.sv ***
// trb_bank: temperature result, limit, hysteresis, power-down and id registers
// assumes a serial engine turns host frames into single-cycle reads and writes
//
// Functional notes
// - temperatures are two's complement, one lsb is an eighth of a degree
// - local result sits in bits 15..4, bits 3..0 read zero
// - first remote result sits in bits 15..4 of its own register
// - second remote result sits left aligned in its own register
// - all result registers read zero after reset until a conversion
// - converter, reference and twelve dac power-down bits, all clear at reset
// - some reset values depend on whether the host port is spi or i2c
// - under i2c the config enables move to the upper byte, low byte resets to ones
`timescale 1ns/1ps
module trb_bank
  import trb_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h0c0d  // arbitrary identification value
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // host port mode, high selects i2c
  input  wire logic              host_is_i2c,
  // register access from the serial engine
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  output logic [15:0]            reg_rdata,
  output logic                   reg_rvalid,
  // conversion results
  input  wire logic              local_upd,
  input  wire logic [11:0]       local_code,
  input  wire logic              remote1_upd,
  input  wire logic [11:0]       remote1_code,
  input  wire logic              remote2_upd,
  input  wire logic [11:0]       remote2_code,
  // configuration to the analog core
  output logic                   local_sensor_en,
  output logic                   remote1_sensor_en,
  output logic                   remote2_sensor_en,
  output logic                   resistance_correction_enable,
  output logic [11:0]            remote1_upper_limit,
  output logic [11:0]            remote1_lower_limit,
  output logic [11:0]            remote2_upper_limit,
  output logic [11:0]            remote2_lower_limit,
  output logic [15:0]            input01_hysteresis,
  output logic [15:0]            input23_hysteresis,
  output logic [15:0]            temp_channel_hysteresis,
  // power-down controls
  output logic                   converter_power_down,
  output logic                   reference_power_down,
  output logic [NUM_DAC-1:0]     output_channel_power_down,
  // one-cycle pulse when software reset key is written
  output logic                   soft_reset_pulse
);

  logic        mode_i2c_r;
  logic        mode_taken_r;
  logic        soft_clr_r;
  logic [15:0] cfg_r;
  logic [15:0] r1_upper_r;
  logic [15:0] r1_lower_r;
  logic [15:0] r2_upper_r;
  logic [15:0] r2_lower_r;
  logic [15:0] hyst01_r;
  logic [15:0] hyst23_r;
  logic [15:0] hyst_temp_r;
  logic [15:0] pd_r;
  logic [15:0] rdata_nxt;
  logic [15:0] local_val;
  logic [15:0] remote1_val;
  logic [15:0] remote2_val;
  logic [3:0]  cfg_bits;
  logic        wr_any;

  assign wr_any = reg_wr;

  // result registers
  trb_result_reg #(.W(RESULT_W)) u_local (
    .clk      (clk),
    .rst_n    (rst_n),
    .clr      (soft_clr_r),
    .upd_en   (local_upd),
    .upd_code (local_code),
    .value    (local_val)
  );

  trb_result_reg #(.W(RESULT_W)) u_remote1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .clr      (soft_clr_r),
    .upd_en   (remote1_upd),
    .upd_code (remote1_code),
    .value    (remote1_val)
  );

  trb_result_reg #(.W(RESULT_W)) u_remote2 (
    .clk      (clk),
    .rst_n    (rst_n),
    .clr      (soft_clr_r),
    .upd_en   (remote2_upd),
    .upd_code (remote2_code),
    .value    (remote2_val)
  );

  // host mode strap caught on the first clock after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_i2c_r   <= 1'b0;
      mode_taken_r <= 1'b0;
    end else if (!mode_taken_r) begin
      mode_i2c_r   <= host_is_i2c;
      mode_taken_r <= 1'b1;
    end
  end

  // software reset: key write pulses a clear of all registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_clr_r <= 1'b0;
    end else begin
      soft_clr_r <= wr_any && reg_addr == OFS_SW_RESET && reg_wdata == SW_RESET_KEY;
    end
  end

  // temperature configuration, layout follows host mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= RST_CFG_SPI;
    end else if (!mode_taken_r || soft_clr_r) begin
      cfg_r <= (mode_taken_r ? mode_i2c_r : host_is_i2c) ? RST_CFG_I2C
                                                         : RST_CFG_SPI;
    end else if (wr_any && reg_addr == OFS_TEMP_CONFIG) begin
      cfg_r <= reg_wdata & (mode_i2c_r ? CFG_I2C_MASK : CFG_SPI_MASK);
    end
  end

  assign cfg_bits = mode_i2c_r ? cfg_r[CFG_I2C_SHIFT +: 4]
                               : cfg_r[CFG_SPI_SHIFT +: 4];

  // limits and hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r1_upper_r  <= RST_UPPER;
      r1_lower_r  <= RST_LOWER;
      r2_upper_r  <= RST_UPPER;
      r2_lower_r  <= RST_LOWER;
      hyst01_r    <= RST_HYST_IN;
      hyst23_r    <= RST_HYST_IN;
      hyst_temp_r <= RST_HYST_TEMP;
    end else if (soft_clr_r) begin
      r1_upper_r  <= RST_UPPER;
      r1_lower_r  <= RST_LOWER;
      r2_upper_r  <= RST_UPPER;
      r2_lower_r  <= RST_LOWER;
      hyst01_r    <= RST_HYST_IN;
      hyst23_r    <= RST_HYST_IN;
      hyst_temp_r <= RST_HYST_TEMP;
    end else if (wr_any) begin
      unique case (reg_addr)
        OFS_R1_UPPER:  r1_upper_r  <= {4'h0, reg_wdata[LIMIT_W-1:0]};
        OFS_R1_LOWER:  r1_lower_r  <= {4'h0, reg_wdata[LIMIT_W-1:0]};
        OFS_R2_UPPER:  r2_upper_r  <= {4'h0, reg_wdata[LIMIT_W-1:0]};
        OFS_R2_LOWER:  r2_lower_r  <= {4'h0, reg_wdata[LIMIT_W-1:0]};
        OFS_HYST01:    hyst01_r    <= reg_wdata & HYST_IN_MASK;
        OFS_HYST23:    hyst23_r    <= reg_wdata & HYST_IN_MASK;
        OFS_HYST_TEMP: hyst_temp_r <= reg_wdata & HYST_TEMP_MASK;
        default: ;
      endcase
    end
  end

  // power-down control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_r <= RST_POWER_DOWN;
    end else if (soft_clr_r) begin
      pd_r <= RST_POWER_DOWN;
    end else if (wr_any && reg_addr == OFS_POWER_DOWN) begin
      pd_r <= reg_wdata & PD_WRITE_MASK;
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (reg_addr)
      OFS_LOCAL_RESULT:   rdata_nxt = local_val;
      OFS_REMOTE1_RESULT: rdata_nxt = remote1_val;
      OFS_REMOTE2_RESULT: rdata_nxt = remote2_val;
      OFS_TEMP_CONFIG:    rdata_nxt = cfg_r;
      OFS_R1_UPPER:       rdata_nxt = r1_upper_r;
      OFS_R1_LOWER:       rdata_nxt = r1_lower_r;
      OFS_R2_UPPER:       rdata_nxt = r2_upper_r;
      OFS_R2_LOWER:       rdata_nxt = r2_lower_r;
      OFS_HYST01:         rdata_nxt = hyst01_r;
      OFS_HYST23:         rdata_nxt = hyst23_r;
      OFS_HYST_TEMP:      rdata_nxt = hyst_temp_r;
      OFS_POWER_DOWN:     rdata_nxt = pd_r;
      OFS_PART_ID:        rdata_nxt = PART_ID;
      default:            rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // registered outputs to the analog core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote2_sensor_en            <= 1'b0;
      remote1_sensor_en            <= 1'b0;
      local_sensor_en              <= 1'b0;
      resistance_correction_enable <= 1'b0;
      remote1_upper_limit          <= 12'h000;
      remote1_lower_limit          <= 12'h000;
      remote2_upper_limit          <= 12'h000;
      remote2_lower_limit          <= 12'h000;
      input01_hysteresis           <= 16'h0000;
      input23_hysteresis           <= 16'h0000;
      temp_channel_hysteresis      <= 16'h0000;
      converter_power_down         <= 1'b0;
      reference_power_down         <= 1'b0;
      output_channel_power_down    <= '0;
      soft_reset_pulse             <= 1'b0;
    end else begin
      remote2_sensor_en            <= cfg_bits[3];
      remote1_sensor_en            <= cfg_bits[2];
      local_sensor_en              <= cfg_bits[1];
      resistance_correction_enable <= cfg_bits[0];
      remote1_upper_limit          <= r1_upper_r[LIMIT_W-1:0];
      remote1_lower_limit          <= r1_lower_r[LIMIT_W-1:0];
      remote2_upper_limit          <= r2_upper_r[LIMIT_W-1:0];
      remote2_lower_limit          <= r2_lower_r[LIMIT_W-1:0];
      input01_hysteresis           <= hyst01_r;
      input23_hysteresis           <= hyst23_r;
      temp_channel_hysteresis      <= hyst_temp_r;
      converter_power_down         <= pd_r[PD_CONVERTER_BIT];
      reference_power_down         <= pd_r[PD_REFERENCE_BIT];
      for (int i = 0; i < NUM_DAC; i++) begin
        output_channel_power_down[i] <= pd_r[PD_DAC0_BIT - i];
      end
      soft_reset_pulse             <= soft_clr_r;
    end
  end

endmodule // trb_bank

// *** trb_pkg.sv ***
// trb_pkg: offsets, field layout and reset values of the temperature result bank
// assumes a 16-bit register word addressed by a 7-bit register index
package trb_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 7;

  // register indices
  localparam logic [6:0] OFS_LOCAL_RESULT   = 7'h00;
  localparam logic [6:0] OFS_REMOTE1_RESULT = 7'h01;
  localparam logic [6:0] OFS_REMOTE2_RESULT = 7'h02;
  localparam logic [6:0] OFS_TEMP_CONFIG    = 7'h0a;
  localparam logic [6:0] OFS_R1_UPPER       = 7'h64;
  localparam logic [6:0] OFS_R1_LOWER       = 7'h65;
  localparam logic [6:0] OFS_R2_UPPER       = 7'h66;
  localparam logic [6:0] OFS_R2_LOWER       = 7'h67;
  localparam logic [6:0] OFS_HYST01         = 7'h68;
  localparam logic [6:0] OFS_HYST23         = 7'h69;
  localparam logic [6:0] OFS_HYST_TEMP      = 7'h6a;
  localparam logic [6:0] OFS_POWER_DOWN     = 7'h6b;
  localparam logic [6:0] OFS_PART_ID        = 7'h6c;
  localparam logic [6:0] OFS_SW_RESET       = 7'h7c;

  // reset values
  localparam logic [15:0] RST_RESULT       = 16'h0000;
  localparam logic [15:0] RST_UPPER        = 16'h07ff;
  localparam logic [15:0] RST_LOWER        = 16'h0800;
  localparam logic [15:0] RST_HYST_IN      = 16'h0810;
  localparam logic [15:0] RST_HYST_TEMP    = 16'h2108;
  localparam logic [15:0] RST_POWER_DOWN   = 16'h0000;
  localparam logic [15:0] RST_CFG_SPI      = 16'h003c;
  localparam logic [15:0] RST_CFG_I2C      = 16'h3cff;

  // field layout
  localparam int unsigned RESULT_LSB       = 4;
  localparam int unsigned RESULT_W         = 12;
  localparam int unsigned LIMIT_W          = 12;
  localparam int unsigned NUM_DAC          = 12;
  localparam int unsigned PD_CONVERTER_BIT = 14;
  localparam int unsigned PD_REFERENCE_BIT = 13;
  localparam int unsigned PD_DAC0_BIT      = 12;
  localparam logic [15:0] PD_WRITE_MASK    = 16'h7ffe;
  localparam logic [15:0] HYST_IN_MASK     = 16'h7ffe;
  localparam logic [15:0] HYST_TEMP_MASK   = 16'h7fff;
  localparam logic [15:0] CFG_SPI_MASK     = 16'h003c;
  localparam logic [15:0] CFG_I2C_MASK     = 16'h3cff;
  localparam int unsigned CFG_SPI_SHIFT    = 2;
  localparam int unsigned CFG_I2C_SHIFT    = 10;

  // software reset key, arbitrary
  localparam logic [15:0] SW_RESET_KEY     = 16'h00a5;

endpackage

// *** trb_result_reg.sv ***
// trb_result_reg: one read-only temperature result register
// assumes the converter pulses upd_en for one cycle with a valid code
`timescale 1ns/1ps
module trb_result_reg
  import trb_pkg::*;
#(
  parameter int unsigned W = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  // converter side
  input  wire logic         upd_en,
  input  wire logic [W-1:0] upd_code,
  // register view
  output logic [15:0]       value
);

  logic [W-1:0] code_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= '0;
    end else if (clr) begin
      code_r <= '0;
    end else if (upd_en) begin
      code_r <= upd_code;
    end
  end

  // left aligned, four low bits read zero
  assign value = {code_r, 4'h0};

endmodule // trb_result_reg

// *** trb_bank_properties.sv ***
// trb_bank_chk: port checker for the result bank
// assumes a bind onto trb_bank, one clock, async active-low reset
`timescale 1ns/1ps
module trb_bank_chk
  import trb_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // register port
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic [15:0]        reg_rdata,
  input wire logic               reg_rvalid,
  // results and controls
  input wire logic               local_upd,
  input wire logic [11:0]        local_code,
  input wire logic [11:0]        remote1_upper_limit,
  input wire logic               converter_power_down,
  input wire logic               reference_power_down,
  input wire logic [NUM_DAC-1:0] output_channel_power_down,
  input wire logic               soft_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] lt_r;
  logic        key_w;
  logic        key_d;
  logic        pdw_w;
  assign key_w = reg_wr && reg_addr == OFS_SW_RESET && reg_wdata == SW_RESET_KEY;
  // a write in the cycle of the soft clear is lost to the clear
  assign pdw_w = reg_wr && reg_addr == OFS_POWER_DOWN && !key_d;
  // last local code taken, cleared one cycle after a key write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lt_r  <= 12'h000;
      key_d <= 1'b0;
    end else begin
      key_d <= key_w;
      if (key_d) lt_r <= 12'h000;
      else if (local_upd) lt_r <= local_code;
    end
  end
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  chk_local_value:
    assert property (reg_rd && reg_addr == OFS_LOCAL_RESULT |=> reg_rdata == {$past(lt_r), 4'h0})
    else $error("local result wrong");
  chk_result_low_zero:
    assert property (reg_rd && reg_addr <= OFS_REMOTE2_RESULT |=> reg_rdata[3:0] == 4'h0)
    else $error("result low bits set");
  chk_pd_unit:
    assert property (pdw_w |=> ##1
      {converter_power_down, reference_power_down} == $past(reg_wdata[14:13], 2))
    else $error("unit power-down wrong");
  chk_pd_channel:
    assert property (pdw_w |=> ##1 output_channel_power_down[0] == $past(reg_wdata[12], 2)
      && output_channel_power_down[11] == $past(reg_wdata[1], 2))
    else $error("channel power-down wrong");
  chk_limit_follow: assert property (reg_wr && reg_addr == OFS_R1_UPPER && !key_d |=> ##1
      remote1_upper_limit == $past(reg_wdata[11:0], 2))
    else $error("limit output wrong");
  chk_soft_pulse: assert property (key_w |=> ##1 soft_reset_pulse)
    else $error("soft reset pulse missing");
  chk_pulse_cause: assert property (soft_reset_pulse |-> $past(key_w, 2))
    else $error("soft reset pulse spurious");
  cov_id_read: cover property (reg_rd && reg_addr == OFS_PART_ID);
  cov_soft: cover property (soft_reset_pulse);
  cov_pd: cover property (converter_power_down && output_channel_power_down[11]);
endmodule // trb_bank_chk

bind trb_bank trb_bank_chk trb_bank_chk_inst (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .local_upd(local_upd), .local_code(local_code), .remote1_upper_limit(remote1_upper_limit),
  .converter_power_down(converter_power_down), .reference_power_down(reference_power_down),
  .output_channel_power_down(output_channel_power_down), .soft_reset_pulse(soft_reset_pulse));

// *** trb_conv_model.sv ***
// trb_conv_model: behavioural converter feeding result codes
// assumes the bench calls convert() between register accesses
`timescale 1ns/1ps
module trb_conv_model (
  // clock
  input wire logic   clk,
  // channel 0 local, 1 and 2 remote
  output logic [2:0]  upd,
  output logic [35:0] codes
);
  initial begin
    upd = 3'h0;
    codes = 36'h0;
  end
  // one-cycle pulse, code not held outside it
  task automatic convert(input int ch, input logic [11:0] c);
    @(negedge clk);
    upd[ch] = 1'b1;
    codes[ch*12 +: 12] = c;
    @(negedge clk);
    upd[ch] = 1'b0;
    codes[ch*12 +: 12] = ~c;
  endtask
endmodule // trb_conv_model

// *** tb_top.sv ***
// tb_top: register-level bench for the result bank
// assumes the converter model and the checker bind are compiled alongside
`timescale 1ns/1ps
module tb_top;
  import trb_pkg::*;
  localparam logic [15:0] ID = 16'h0c0d; // arbitrary identification value
  logic                clk, rst_n, host_is_i2c, reg_wr, reg_rd, reg_rvalid;
  logic [ADDR_W-1:0]   reg_addr;
  logic [15:0]         reg_wdata, reg_rdata;
  logic                cpd, rpd;
  logic [NUM_DAC-1:0]  ocpd;
  logic [3:0]          en;
  logic [11:0]         lim [4];
  logic [15:0]         hys [3];
  logic [2:0]          upd;
  logic [35:0]         codes;
  int                  miscompares = 0, n_compared = 0, cyc = 0;
  logic [6:0]  ra [15] = '{7'h00, 7'h01, 7'h02, 7'h0a, 7'h64, 7'h65, 7'h66, 7'h67,
                            7'h68, 7'h69, 7'h6a, 7'h6b, 7'h6c, 7'h7c, 7'h30};
  logic [15:0] rv [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h003c, 16'h07ff, 16'h0800,
                            16'h07ff, 16'h0800, 16'h0810, 16'h0810, 16'h2108, 16'h0000,
                            ID, 16'h0000, 16'h0000};
  logic [15:0] me [7] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff, 16'h7ffe, 16'h7ffe, 16'h7fff};
  logic [15:0] pw [5] = '{16'hffff, 16'h4000, 16'h2000, 16'h1002, 16'h0001};

  trb_conv_model trb_conv_model_inst (.clk(clk), .upd(upd), .codes(codes));
  trb_bank #(.PART_ID(ID)) trb_bank_inst (
    .clk(clk), .rst_n(rst_n), .host_is_i2c(host_is_i2c), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .local_upd(upd[0]), .local_code(codes[11:0]), .remote1_upd(upd[1]),
    .remote1_code(codes[23:12]), .remote2_upd(upd[2]), .remote2_code(codes[35:24]),
    .local_sensor_en(en[1]), .remote1_sensor_en(en[2]), .remote2_sensor_en(en[3]),
    .resistance_correction_enable(en[0]), .remote1_upper_limit(lim[0]),
    .remote1_lower_limit(lim[1]), .remote2_upper_limit(lim[2]),
    .remote2_lower_limit(lim[3]), .input01_hysteresis(hys[0]),
    .input23_hysteresis(hys[1]), .temp_channel_hysteresis(hys[2]), .converter_power_down(cpd),
    .reference_power_down(rpd), .output_channel_power_down(ocpd), .soft_reset_pulse());

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] pd_exp(input logic [15:0] w);
    pd_exp = {2'b00, w[14], w[13], 12'h000};
    for (int i = 0; i < 12; i++) pd_exp[i] = w[12-i];
  endfunction
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask
  task automatic do_reset(input logic i2c);
    rst_n = 1'b0;
    host_is_i2c = i2c;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    do_reset(1'b0);
    for (int i = 0; i < 15; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 4; i++) chk({4'h0, lim[i]}, rv[i+4]);
    for (int i = 0; i < 3; i++) chk(hys[i], rv[i+8]);
    chk({12'h000, en}, 16'h000f);
    wr(OFS_TEMP_CONFIG, 16'hffd3);
    rd(OFS_TEMP_CONFIG, 16'h0010);
    chk({12'h000, en}, 16'h0004);
    wr(OFS_LOCAL_RESULT, 16'hffff);
    wr(OFS_PART_ID, 16'hffff);
    rd(OFS_LOCAL_RESULT, 16'h0000);
    rd(OFS_PART_ID, ID);
    trb_conv_model_inst.convert(0, 12'h800);
    trb_conv_model_inst.convert(1, 12'h7ff);
    trb_conv_model_inst.convert(2, 12'hff8);
    rd(OFS_LOCAL_RESULT, 16'h8000);
    rd(OFS_REMOTE1_RESULT, 16'h7ff0);
    rd(OFS_REMOTE2_RESULT, 16'hff80);
    for (int i = 0; i < 7; i++) begin
      wr(ra[i+4], 16'hffff);
      rd(ra[i+4], me[i]);
    end
    for (int i = 0; i < 4; i++) chk({4'h0, lim[i]}, me[i]);
    for (int i = 0; i < 3; i++) chk(hys[i], me[i+4]);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_POWER_DOWN, pw[i]);
      @(negedge clk);
      chk({2'b00, cpd, rpd, ocpd}, pd_exp(pw[i]));
      rd(OFS_POWER_DOWN, pw[i] & 16'h7ffe);
    end
    wr(OFS_SW_RESET, 16'h1234);
    rd(OFS_R1_UPPER, 16'h0fff);
    wr(OFS_POWER_DOWN, 16'h7ffe);
    wr(OFS_SW_RESET, SW_RESET_KEY);
    repeat (3) @(negedge clk);
    rd(OFS_R1_UPPER, 16'h07ff);
    rd(OFS_POWER_DOWN, 16'h0000);
    chk({2'b00, cpd, rpd, ocpd}, 16'h0000);
    rd(OFS_TEMP_CONFIG, 16'h003c);
    rd(OFS_LOCAL_RESULT, 16'h0000);
    chk({4'h0, lim[0]}, 16'h07ff);
    chk({12'h000, en}, 16'h000f);
    do_reset(1'b1);
    rd(OFS_TEMP_CONFIG, 16'h3cff);
    chk({12'h000, en}, 16'h000f);
    wr(OFS_TEMP_CONFIG, 16'h243c);
    rd(OFS_TEMP_CONFIG, 16'h243c);
    chk({12'h000, en}, 16'h0009);
    rd(OFS_LOCAL_RESULT, 16'h0000);
    summarize();
  end
endmodule // tb_top
